// File: src/scc_sync_control.sv
/*
  Sync, clamp and coast control bank with its live sync detection.
  Assumes synchronous sync inputs, a decoded byte-wide register port
  behind the 2-wire serial interface, and a 250 MHz core clock.
*/
// Overview of operation
// - Vsync override uses manual select, else auto
// - Vsync select: raw input or separated sync
// - Clamp source: hsync or external clamp input
// - Clamp polarity applies only to external clamp
// - Coast source: coast input or vertical sync
// - Coast polarity override: auto or programmed
// - Coast polarity bit: low or high active
// - Seek override permits or forbids low power
// - Active-low bit powers down whole chip
// - Bits 7:3 set green slicer level
// - Per-channel clamp: ground or midscale level
// - Separator counts 5 MHz ticks to threshold
// - Coast asserts programmed lines before vsync
// - Coast holds programmed lines after vsync
// - Status bit 7 shows hsync present
// - Status bit 6 shows hsync in use
// - Status bit 5 shows hsync polarity
// - Status bit 4 shows vsync present
// - Status bit 3 shows vsync in use
// - Status bit 2 shows output vsync polarity
// - Status bit 1 shows green sync present
`timescale 1ns/1ps
`include "scc_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Presence and polarity watcher for one sync line
module scc_sync_watch #(
  parameter int TIMEOUT = 1000000
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Watched line
  input  wire logic line_in,
  // Results
  output logic      present,
  output logic      active_high
);
  logic        prev_q;     // Previous line level
  logic [23:0] idle_q;     // Cycles since last edge
  logic [23:0] run_q;      // Length of current level
  logic [23:0] high_len_q; // Last high pulse length
  logic [23:0] low_len_q;  // Last low pulse length

  initial
  begin
    if (TIMEOUT < 2 || TIMEOUT > 24'hFFFFFE)
      $error("scc_sync_watch: TIMEOUT out of range");
  end

  // Edge tracking and run lengths
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      prev_q     <= 1'b0;
      idle_q     <= 24'hFFFFFF;
      run_q      <= 24'h000000;
      high_len_q <= 24'h000000;
      low_len_q  <= 24'h000000;
    end
    else
    begin
      prev_q <= line_in;
      if (line_in != prev_q)
      begin
        // Edge: record finished level length
        idle_q <= 24'h000000;
        run_q  <= 24'h000001;
        if (prev_q)
          high_len_q <= run_q;
        else
          low_len_q <= run_q;
      end
      else
      begin
        // Saturate both counters
        if (idle_q != 24'hFFFFFF)
          idle_q <= idle_q + 24'h000001;
        if (run_q != 24'hFFFFFF)
          run_q <= run_q + 24'h000001;
      end
    end
  end

  // Present while edges keep coming; the shorter level is the pulse
  assign present     = (idle_q < 24'(TIMEOUT));
  assign active_high = (high_len_q < low_len_q);
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top: register bank, sync selection, separator, clamp and coast
module scc_sync_control #(
  parameter int DETECT_TIMEOUT = 1000000  // Cycles without edge before absent
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Register port behind the serial interface
  input  wire logic [7:0]       reg_addr,
  input  wire scc_pkg::scc_byte_t reg_wdata,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  output scc_pkg::scc_byte_t    reg_rdata,
  // Vertical sync selection bits held elsewhere
  input  wire logic             vs_override,
  input  wire logic             vs_select,
  // Sync and control inputs from the source
  input  wire logic             hsync_in,
  input  wire logic             vsync_in,
  input  wire logic             green_sync_in,
  input  wire logic             clamp_in,
  input  wire logic             coast_in,
  // Processed outputs
  output logic                  vsync_out,
  output logic                  clamp_out,
  output logic                  coast_out,
  output scc_pkg::scc_level_t   slicer_level,
  output scc_pkg::scc_mid_t     clamp_midscale,
  output logic                  low_power_allowed,
  output logic                  full_chip_sleep_n
);
  import scc_pkg::*;

  localparam int TICK_DIV = `SCC_TICK_DIV;  // Core cycles per 5 MHz tick

  initial
  begin
    if (DETECT_TIMEOUT < 2 || DETECT_TIMEOUT > 24'hFFFFFE)
      $error("scc_sync_control: DETECT_TIMEOUT out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register storage
  scc_byte_t ctl_q;        // Clamp and coast control
  scc_byte_t slicer_q;     // Slicer level and clamp levels
  scc_byte_t sep_thr_q;    // Separator count threshold
  scc_byte_t lead_q;       // Coast lines before vsync
  scc_byte_t trail_q;      // Coast lines after vsync
  scc_byte_t status;       // Live sync status

  // Register writes
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      ctl_q     <= `SCC_RST_CLAMP_COAST;
      slicer_q  <= `SCC_RST_SLICER;
      sep_thr_q <= `SCC_RST_SEP_THR;
      lead_q    <= `SCC_RST_COAST_LEAD;
      trail_q   <= `SCC_RST_COAST_TRAIL;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `SCC_OFS_CLAMP_COAST: ctl_q     <= reg_wdata;
        `SCC_OFS_SLICER:      slicer_q  <= reg_wdata;
        `SCC_OFS_SEP_THR:     sep_thr_q <= reg_wdata;
        `SCC_OFS_COAST_LEAD:  lead_q    <= reg_wdata;
        `SCC_OFS_COAST_TRAIL: trail_q   <= reg_wdata;
        default:              ;  // Status and unmapped: ignored
      endcase
    end
  end

  // Register reads, status sampled live without side effects
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        `SCC_OFS_CLAMP_COAST: reg_rdata <= ctl_q;
        `SCC_OFS_SLICER:      reg_rdata <= slicer_q;
        `SCC_OFS_SEP_THR:     reg_rdata <= sep_thr_q;
        `SCC_OFS_COAST_LEAD:  reg_rdata <= lead_q;
        `SCC_OFS_COAST_TRAIL: reg_rdata <= trail_q;
        `SCC_OFS_STATUS:      reg_rdata <= status;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sync watchers
  logic hs_present, hs_high;    // Dedicated hsync
  logic vs_present, vs_high;    // Dedicated vsync
  logic sog_present, sog_high;  // Sync from green
  logic co_present, co_high;    // External coast
  logic vo_present, vo_high;    // Output vsync

  scc_sync_watch #(.TIMEOUT(DETECT_TIMEOUT)) u_hs_watch (
    .ref_clk(ref_clk), .reset_n(reset_n), .line_in(hsync_in),
    .present(hs_present), .active_high(hs_high));
  scc_sync_watch #(.TIMEOUT(DETECT_TIMEOUT)) u_vs_watch (
    .ref_clk(ref_clk), .reset_n(reset_n), .line_in(vsync_in),
    .present(vs_present), .active_high(vs_high));
  scc_sync_watch #(.TIMEOUT(DETECT_TIMEOUT)) u_sog_watch (
    .ref_clk(ref_clk), .reset_n(reset_n), .line_in(green_sync_in),
    .present(sog_present), .active_high(sog_high));
  scc_sync_watch #(.TIMEOUT(DETECT_TIMEOUT)) u_co_watch (
    .ref_clk(ref_clk), .reset_n(reset_n), .line_in(coast_in),
    .present(co_present), .active_high(co_high));
  scc_sync_watch #(.TIMEOUT(DETECT_TIMEOUT)) u_vo_watch (
    .ref_clk(ref_clk), .reset_n(reset_n), .line_in(vsync_out),
    .present(vo_present), .active_high(vo_high));

  // Hsync in use: dedicated input unless only green carries sync
  logic active_horizontal_source;
  logic hs_level;   // Active-high horizontal sync in use
  assign active_horizontal_source = !hs_present && sog_present;
  assign hs_level = active_horizontal_source ? (green_sync_in ^ !sog_high)
                                             : (hsync_in ^ !hs_high);

  //////////////////////////////////////////////////////////////////////////////
  // Separator: 5 MHz tick and pulse-width counter
  logic [5:0] tick_cnt_q;  // Tick divider
  logic       tick;        // One cycle per 5 MHz period
  logic [7:0] sep_cnt_q;   // Ticks in current sync pulse
  logic       sep_vs_q;    // Separated vertical sync
  assign tick = (tick_cnt_q == 6'(TICK_DIV - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      tick_cnt_q <= 6'h00;
    else
      tick_cnt_q <= tick ? 6'h00 : tick_cnt_q + 6'h01;
  end

  // Long pulses reaching the threshold are vertical sync
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      sep_cnt_q <= 8'h00;
      sep_vs_q  <= 1'b0;
    end
    else if (!hs_level)
    begin
      sep_cnt_q <= 8'h00;
      sep_vs_q  <= 1'b0;
    end
    else if (tick && sep_cnt_q != 8'hFF)
    begin
      sep_cnt_q <= sep_cnt_q + 8'h01;
      if (sep_cnt_q + 8'h01 >= sep_thr_q)
        sep_vs_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Vertical sync routing
  logic active_vertical_source;
  assign active_vertical_source = vs_override ? vs_select
                                              : !vs_present;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      vsync_out <= 1'b0;
    else
      vsync_out <= active_vertical_source ? sep_vs_q : vsync_in;
  end

  // Live status word
  assign status = {hs_present,
                   active_horizontal_source,
                   hs_high,
                   vs_present,
                   active_vertical_source,
                   vo_high,
                   sog_present,
                   co_high};

  //////////////////////////////////////////////////////////////////////////////
  // Clamp generation
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      clamp_out <= 1'b0;
    else if (ctl_q[`SCC_BIT_CLAMP_SRC])
      clamp_out <= clamp_in ^ ctl_q[`SCC_BIT_CLAMP_POL];
    else
      clamp_out <= hs_level;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Coast window around vertical sync
  logic       vs_level;       // Active-high vsync in use
  logic       vs_prev_q;      // Previous vsync level
  logic       hs_prev_q;      // Previous hsync level
  logic       hs_rise;        // Line start
  logic [9:0] line_cnt_q;     // Lines since vsync start
  logic [9:0] frame_lines_q;  // Lines in last frame
  logic [7:0] trail_cnt_q;    // Lines left after vsync
  logic       vs_window;      // Coast from vsync timing
  logic       ext_coast;      // Coast from external input
  assign vs_level = vsync_out ^ !vo_high;
  assign hs_rise  = hs_level && !hs_prev_q;

  // Line counting and post-vsync hold
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      vs_prev_q     <= 1'b0;
      hs_prev_q     <= 1'b0;
      line_cnt_q    <= 10'h000;
      frame_lines_q <= 10'h000;
      trail_cnt_q   <= 8'h00;
    end
    else
    begin
      vs_prev_q <= vs_level;
      hs_prev_q <= hs_level;
      if (vs_level && !vs_prev_q)
      begin
        // Frame start: keep length for the lead window
        frame_lines_q <= line_cnt_q;
        line_cnt_q    <= 10'h000;
      end
      else if (hs_rise && line_cnt_q != 10'h3FF)
        line_cnt_q <= line_cnt_q + 10'h001;
      if (!vs_level && vs_prev_q)
        trail_cnt_q <= trail_q;
      else if (hs_rise && trail_cnt_q != 8'h00)
        trail_cnt_q <= trail_cnt_q - 8'h01;
    end
  end

  assign vs_window = vs_level || (trail_cnt_q != 8'h00)
                     || (frame_lines_q != 10'h000 &&
                         line_cnt_q + {2'b00, lead_q} >= frame_lines_q);
  assign ext_coast = coast_in ^ !(ctl_q[`SCC_BIT_COAST_OVR]
                                  ? ctl_q[`SCC_BIT_COAST_POL]
                                  : co_high);

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      coast_out <= 1'b0;
    else
      coast_out <= ctl_q[`SCC_BIT_COAST_SRC] ? vs_window : ext_coast;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Static control outputs
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      slicer_level      <= 5'(`SCC_RST_SLICER >> `SCC_SLICER_LSB);
      clamp_midscale    <= 3'h0;
      low_power_allowed <= 1'b1;
      full_chip_sleep_n <= 1'b1;
    end
    else
    begin
      slicer_level      <= slicer_q[`SCC_SLICER_MSB:`SCC_SLICER_LSB];
      clamp_midscale    <= {slicer_q[`SCC_BIT_MID_RED],
                            slicer_q[`SCC_BIT_MID_GREEN],
                            slicer_q[`SCC_BIT_MID_BLUE]};
      low_power_allowed <= ctl_q[`SCC_BIT_SEEK_OVR];
      full_chip_sleep_n <= ctl_q[`SCC_BIT_SLEEP_N];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_vs_route;
    vs_override |=> vsync_out == $past(vs_select ? sep_vs_q : vsync_in);
  endproperty
  a_vs_route: assert property (p_vs_route) else $error("vsync routing wrong");
  property p_clamp_ext;
    ctl_q[7] |=> clamp_out == ($past(clamp_in) ^ $past(ctl_q[6]));
  endproperty
  a_clamp_ext: assert property (p_clamp_ext) else $error("clamp polarity wrong");
  property p_clamp_hs;
    !ctl_q[7] |=> clamp_out == $past(hs_level);
  endproperty
  a_clamp_hs: assert property (p_clamp_hs) else $error("clamp not from hsync");
  property p_coast_ovr;
    (!ctl_q[5] && ctl_q[4]) |=> coast_out == ($past(coast_in) ~^ $past(ctl_q[3]));
  endproperty
  a_coast_ovr: assert property (p_coast_ovr) else $error("coast polarity wrong");
  property p_coast_vs;
    (ctl_q[5] && vs_level) |=> coast_out;
  endproperty
  a_coast_vs: assert property (p_coast_vs) else $error("coast missing in vsync");
  property p_trail_load;
    (!vs_level && vs_prev_q) |=> trail_cnt_q == $past(trail_q);
  endproperty
  a_trail_load: assert property (p_trail_load) else $error("post-coast not loaded");
  property p_sleep;
    ##1 full_chip_sleep_n == $past(ctl_q[1]) && low_power_allowed == $past(ctl_q[2]);
  endproperty
  a_sleep: assert property (p_sleep) else $error("power control outputs stale");
  property p_sep_clear;
    !hs_level |=> !sep_vs_q && sep_cnt_q == 8'h00;
  endproperty
  a_sep_clear: assert property (p_sep_clear) else $error("separator not cleared");
  property p_status_read;
    (reg_read && reg_addr == 8'h14) |=> reg_rdata == $past(status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read not live");
endmodule

// File: src/scc_map.svh
/*
  Register offsets, field positions, reset values and timing counts
  for the sync, clamp and coast control bank.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

// Register offsets
`define SCC_OFS_CLAMP_COAST   8'h0F
`define SCC_OFS_SLICER        8'h10
`define SCC_OFS_SEP_THR       8'h11
`define SCC_OFS_COAST_LEAD    8'h12
`define SCC_OFS_COAST_TRAIL   8'h13
`define SCC_OFS_STATUS        8'h14

// Reset values
`define SCC_RST_CLAMP_COAST   8'h4E
`define SCC_RST_SLICER        8'hB8
`define SCC_RST_SEP_THR       8'h20
`define SCC_RST_COAST_LEAD    8'h00
`define SCC_RST_COAST_TRAIL   8'h00

// Clamp and coast control fields
`define SCC_BIT_CLAMP_SRC     7
`define SCC_BIT_CLAMP_POL     6
`define SCC_BIT_COAST_SRC     5
`define SCC_BIT_COAST_OVR     4
`define SCC_BIT_COAST_POL     3
`define SCC_BIT_SEEK_OVR      2
`define SCC_BIT_SLEEP_N       1

// Slicer level field and clamp level bits
`define SCC_SLICER_MSB        7
`define SCC_SLICER_LSB        3
`define SCC_BIT_MID_RED       2
`define SCC_BIT_MID_GREEN     1
`define SCC_BIT_MID_BLUE      0

// Status fields
`define SCC_ST_HS_PRESENT     7
`define SCC_ST_HS_SOURCE      6
`define SCC_ST_HS_POL         5
`define SCC_ST_VS_PRESENT     4
`define SCC_ST_VS_SOURCE      3
`define SCC_ST_VS_POL         2
`define SCC_ST_SOG_PRESENT    1
`define SCC_ST_COAST_POL      0

// Timing: core clock and separator tick, in MHz
`define SCC_CORE_MHZ          250
`define SCC_TICK_MHZ          5
`define SCC_TICK_DIV          (`SCC_CORE_MHZ / `SCC_TICK_MHZ)

`endif

// File: src/scc_pkg.sv
/*
  Types shared by the sync, clamp and coast control bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scc_pkg;
  typedef logic [7:0] scc_byte_t;   // One register byte
  typedef logic [4:0] scc_level_t;  // Slicer comparison level
  typedef logic [2:0] scc_mid_t;    // Per-channel midscale clamp select
endpackage

// File: testbench/scc_sync_source.sv
/*
  Graphics source model: drives horizontal, vertical and green sync.
  Assumes the bench holds it off until wanted; idle lines sit inactive.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Sync generator with selectable polarity
module scc_sync_source #(
  parameter int LINE_CLKS   = 40, // Clocks per line
  parameter int HS_CLKS     = 4,  // Sync pulse width in clocks
  parameter int FRAME_LINES = 4   // Lines per frame
) (
  // Clock
  input  wire logic ref_clk,
  // Control from the bench
  input  wire logic en,
  input  wire logic act_high,
  // Sync lines to the device
  output logic      hsync_in,
  output logic      vsync_in,
  output logic      green_sync_in
);
  int pix;  // Position within the line
  int line; // Line within the frame

  // Quiet start
  initial
  begin
    pix = 0;
    line = 0;
    hsync_in = 1'b0;
    vsync_in = 1'b0;
    green_sync_in = 1'b0;
  end

  // Step counters just after the edge, then drive levels
  always @(posedge ref_clk)
  begin
    #1;
    if (!en)
    begin
      pix = 0;
      line = 0;
    end
    else
    begin
      pix = (pix + 1) % LINE_CLKS;
      if (pix == 0)
        line = (line + 1) % FRAME_LINES;
    end
    hsync_in = (en && pix < HS_CLKS) ^ ~act_high;
    green_sync_in = hsync_in;
    vsync_in = (en && line == 0) ^ ~act_high;
  end
endmodule

// File: testbench/test_sync_clamp_coast_control.sv
/*
  Self-checking bench for the sync, clamp and coast control bank.
  Assumes the decoded register port and the sync source model.
*/
`timescale 1ns/1ps
`include "scc_map.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end

////////////////////////////////////////////////////////////////////////////////
module test_sync_clamp_coast_control;
  import scc_pkg::*;
  // Clock, reset and register port
  logic       ref_clk, reset_n, reg_write, reg_read;
  logic [7:0] reg_addr;
  scc_byte_t  reg_wdata, reg_rdata, v;
  // Control and sync
  logic       vs_override, vs_select, clamp_in, coast_in, src_en, src_high;
  logic       hsync_in, vsync_in, green_sync_in, last, cref, kref;
  // Outputs
  logic       vsync_out, clamp_out, coast_out, low_power_allowed, full_chip_sleep_n;
  scc_level_t slicer_level;
  scc_mid_t   clamp_midscale;
  int         errors, cmp_count;
  scc_byte_t  rst_tab[5] = '{`SCC_RST_CLAMP_COAST, `SCC_RST_SLICER, `SCC_RST_SEP_THR,
                             `SCC_RST_COAST_LEAD, `SCC_RST_COAST_TRAIL};
  scc_byte_t  pat_tab[5] = '{8'hA5, 8'h5A, 8'hFF, 8'h01, 8'h80};
  scc_byte_t  pwr_tab[4] = '{8'h0C, 8'h0A, 8'h00, 8'h06};
  scc_byte_t  path_tab[6] = '{8'hC6, 8'h86, 8'h1E, 8'h16, 8'h36, 8'h46};

  scc_sync_control #(.DETECT_TIMEOUT(200)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .vs_override(vs_override),
    .vs_select(vs_select), .hsync_in(hsync_in), .vsync_in(vsync_in),
    .green_sync_in(green_sync_in), .clamp_in(clamp_in), .coast_in(coast_in),
    .vsync_out(vsync_out), .clamp_out(clamp_out), .coast_out(coast_out),
    .slicer_level(slicer_level), .clamp_midscale(clamp_midscale),
    .low_power_allowed(low_power_allowed), .full_chip_sleep_n(full_chip_sleep_n));

  scc_sync_source src (.ref_clk(ref_clk), .en(src_en), .act_high(src_high),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .green_sync_in(green_sync_in));

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  // One register write, held over its taking edge
  task automatic wr(input logic [7:0] a, input scc_byte_t d);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge ref_clk);
    #1 reg_write = 1'b0;
  endtask

  // One register read, data taken after its edge
  task automatic rd(input logic [7:0] a, output scc_byte_t d);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_read = 1'b1;
    @(posedge ref_clk);
    #1 reg_read = 1'b0;
    d = reg_rdata;
  endtask

  // Verdict and end of run
  task automatic conclude();
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #200000;
    errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    {reg_write, reg_read, vs_override, vs_select, clamp_in, coast_in} = '0;
    {src_en, src_high} = 2'b01;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    errors = 0;
    cmp_count = 0;
    repeat (12) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    // Reset values at the outputs and in the table
    `CHK(slicer_level, 5'h17)
    `CHK(clamp_midscale, 3'h0)
    `CHK({low_power_allowed, full_chip_sleep_n}, 2'b11)
    for (int i = 0; i < 5; i++)
    begin
      rd(`SCC_OFS_CLAMP_COAST + i, v);
      `CHK(v, rst_tab[i])
    end
    // Unmapped and read-only places
    wr(8'h15, 8'hFF);
    wr(`SCC_OFS_STATUS, 8'hFF);
    rd(8'h15, v);
    `CHK(v, 8'h00)
    rd(8'h0E, v);
    `CHK(v, 8'h00)
    rd(`SCC_OFS_CLAMP_COAST, v);
    `CHK(v, `SCC_RST_CLAMP_COAST)
    // Write and read back every control byte
    for (int i = 0; i < 5; i++)
    begin
      wr(`SCC_OFS_CLAMP_COAST + i, pat_tab[i]);
      rd(`SCC_OFS_CLAMP_COAST + i, v);
      `CHK(v, pat_tab[i])
    end
    wr(`SCC_OFS_SEP_THR, 8'h20);
    // Power-down and low-power permission
    foreach (pwr_tab[i])
    begin
      wr(`SCC_OFS_CLAMP_COAST, pwr_tab[i]);
      @(posedge ref_clk);
      #1 `CHK(full_chip_sleep_n, pwr_tab[i][1])
      `CHK(low_power_allowed, pwr_tab[i][2])
    end
    // Slicer level and clamp levels
    foreach (pat_tab[i])
    begin
      wr(`SCC_OFS_SLICER, pat_tab[i]);
      @(posedge ref_clk);
      #1 `CHK(slicer_level, pat_tab[i][7:3])
      `CHK(clamp_midscale, pat_tab[i][2:0])
    end
    // Clamp and coast routing and polarity
    foreach (path_tab[i])
    begin
      v = path_tab[i];
      wr(`SCC_OFS_CLAMP_COAST, v);
      for (int b = 0; b < 2; b++)
      begin
        @(posedge ref_clk);
        #1 {clamp_in, coast_in} = {2{b[0]}};
        @(posedge ref_clk);
        #1 if (b == 0) {cref, kref} = {clamp_out, coast_out};
        `CHK(clamp_out, v[7] ? (b[0] ^ v[6]) : cref)
        if (v[4] || v[5])
          `CHK(coast_out, v[5] ? kref : (b[0] ~^ v[3]))
      end
    end
    // Live status and vertical sync routing for both polarities
    for (int h = 0; h < 2; h++)
    begin
      src_high = h[0];
      src_en = 1'b1;
      vs_override = 1'b0;
      repeat (400) @(posedge ref_clk);
      for (int k = 0; k < 2; k++)
      begin
        rd(`SCC_OFS_STATUS, v);
        `CHK(v & 8'hFE, h ? 8'hB6 : 8'h92)
      end
      for (int o = 0; o < 2; o++)
      begin
        vs_override = ~o[0];
        @(posedge ref_clk);
        #2 last = vsync_in;
        repeat (200)
        begin
          @(posedge ref_clk);
          #2 `CHK(vsync_out, last)
          last = vsync_in;
        end
      end
      src_en = 1'b0;
      repeat (300) @(posedge ref_clk);
      rd(`SCC_OFS_STATUS, v);
      `CHK(v & 8'hDA, 8'h08)
    end
    rd(`SCC_OFS_CLAMP_COAST, v);
    `CHK(v, path_tab[5])
    conclude();
  end
endmodule
